// >>> design/atr_pkg.sv
package atr_pkg;
  localparam int NCH = 20;
  localparam logic [4:0] TP_FIRST = 5'h00;
  localparam logic [4:0] TP_LAST = 5'h0F;
  localparam logic [4:0] LP_FIRST = 5'h10;
  localparam logic [4:0] LP_LAST = 5'h13;
  localparam logic [3:0] CONSEC = 4'hF;
  localparam int CLK_HZ = 200_000_000;
  localparam int RETRY_UNIT_US = 1000;
  localparam int RETRY_UNIT_CYC = (CLK_HZ / 1_000_000) * RETRY_UNIT_US;
  localparam int FCC_REF_HZ = 16_000_000;
  localparam logic [2:0] LEN_LIN_MAX = 3'h4;
  localparam logic [2:0] LEN_EXP_OFS = 3'h2;
  localparam logic [2:0] CK_TOP = 3'h7;
  localparam logic [6:0] PHASE_BASE = 7'h02;
  localparam logic [7:0] COMP_RST = 8'h00;
  localparam logic [7:0] SAR_TOP = 8'h80;
  localparam logic [7:0] GAIN_MAX = 8'hFF;

  typedef enum logic [1:0] {S_IDLE, S_TRY, S_MEAS, S_FINAL} atr_state_e;

  // a length setting becomes a number of phase steps
  function automatic logic [5:0] len_term(input logic [2:0] l);
    logic [5:0] r;
    r = (l > LEN_LIN_MAX) ? (6'h01 << (l - LEN_EXP_OFS)) : {3'h0, l};
    return r;
  endfunction : len_term

  // value lies outside target plus or minus limit
  function automatic logic out_rng(input logic [15:0] v, input logic [15:0] t,
                                   input logic [15:0] l);
    logic [16:0] hi;
    logic [16:0] lo;
    hi = {1'b0, t} + {1'b0, l};
    lo = {1'b0, t} - {1'b0, l};
    return ({1'b0, v} > hi) || (!lo[16] && ({1'b0, v} < lo));
  endfunction : out_rng
endpackage : atr_pkg

// >>> design/atr_comp_mem.sv
// compensation store, one byte per channel, registered read
module atr_comp_mem (
  input logic clock,
  input logic we,
  input logic [4:0] waddr,
  input logic [7:0] wdata,
  input logic [4:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [atr_pkg::NCH];

  // no reset on the array; read of an unwritten entry is don't-care
  always_ff @(posedge clock) begin
    if (we && (waddr < 5'(atr_pkg::NCH))) begin
      mem_q[waddr] <= wdata;
    end
  end

  // out-of-range addresses read as zero
  always_ff @(posedge clock) begin
    rdata <= (raddr < 5'(atr_pkg::NCH)) ? mem_q[raddr] : atr_pkg::COMP_RST;
  end
endmodule : atr_comp_mem

// >>> design/atr_tune_ctrl.sv
module atr_tune_ctrl #(
  parameter int RETRY_UNIT_CYC = atr_pkg::RETRY_UNIT_CYC
) (
  input logic clock,
  input logic rst,
  input logic [7:0] global_gain_multiplier,
  input logic [7:0] lowpower_gain_multiplier,
  input logic [7:0] channel_gain_adjust,
  input logic run_autotune_set,
  output logic run_autotune_bit,
  input logic lowpower_mode,
  input logic comm_window_open,
  output logic comm_hold,
  input logic [15:0] tp_target,
  input logic [15:0] lp_target,
  input logic [15:0] tp_drift_limit,
  input logic [15:0] lp_drift_limit,
  input logic [15:0] max_count_limit,
  input logic [15:0] min_count_drop,
  input logic [7:0] comp_low_limit,
  input logic [7:0] comp_high_limit,
  input logic [7:0] retry_time,
  input logic retune_enable,
  input logic lowpower_retune_enable,
  input logic mon_valid,
  input logic [4:0] mon_chan,
  input logic [15:0] mon_count,
  input logic [15:0] mon_ref,
  input logic mon_snap,
  output logic meas_req,
  output logic [4:0] meas_chan,
  output logic [7:0] meas_comp,
  output logic [7:0] meas_gain,
  input logic meas_done,
  input logic [15:0] meas_count,
  output logic retune_happened,
  output logic lowpower_retune_happened,
  output logic tune_fault,
  output logic lowpower_tune_fault,
  output logic retry_holdoff,
  input logic [4:0] comp_rd_addr,
  output logic [7:0] comp_rd_data,
  input logic [2:0] charge_clock_divider_sel,
  input logic [2:0] charge_up_length,
  input logic [2:0] charge_pass_length,
  input logic [1:0] extra_phase,
  output logic [22:0] charge_freq_hz
);
  atr_pkg::atr_state_e state_q;
  logic [4:0] ch_q;
  logic [7:0] comp_q;
  logic [7:0] bit_q;
  logic mode_q;
  logic retune_q;
  logic err_q;
  logic run_q;
  logic pend_q;
  logic [7:0] gain_q;
  logic tp_fault_q;
  logic lp_fault_q;
  logic tp_rt_q;
  logic lp_rt_q;
  logic [7:0] hold_q;
  logic [17:0] tick_cnt_q;
  logic [22:0] freq_q;
  logic [3:0] maxc_q [atr_pkg::NCH];
  logic [3:0] dropc_q [atr_pkg::NCH];

  // gain of the channel under measurement, saturated to one byte
  wire ch_lp_w = ch_q >= atr_pkg::LP_FIRST;
  wire signed [9:0] gain_sum_w = $signed({2'b00, global_gain_multiplier})
                               + 10'(signed'(channel_gain_adjust));
  wire [7:0] tp_gain_w = gain_sum_w[9] ? atr_pkg::COMP_RST
                       : (gain_sum_w[8] ? atr_pkg::GAIN_MAX : gain_sum_w[7:0]);
  wire [7:0] gain_w = ch_lp_w ? lowpower_gain_multiplier : tp_gain_w;

  // per-mode target and drift limit for search and monitor
  wire [15:0] srch_tgt_w = mode_q ? lp_target : tp_target;
  wire [15:0] srch_lim_w = mode_q ? lp_drift_limit : tp_drift_limit;
  wire mon_lp_w = mon_chan >= atr_pkg::LP_FIRST;
  wire [15:0] mon_tgt_w = mon_lp_w ? lp_target : tp_target;
  wire [15:0] mon_lim_w = mon_lp_w ? lp_drift_limit : tp_drift_limit;
  wire mon_ok_w = mon_valid && (mon_chan < 5'(atr_pkg::NCH));

  // retune trigger conditions seen on one monitor sample
  wire drift_w = atr_pkg::out_rng(mon_ref, mon_tgt_w, mon_lim_w);
  wire over_w = mon_count > max_count_limit;
  wire [15:0] dip_w = mon_ref - mon_count;
  wire drop_w = (mon_ref > mon_count) && (dip_w > min_count_drop) && !mon_snap;
  wire [3:0] maxc_w = mon_ok_w ? maxc_q[mon_chan] : 4'h0;
  wire [3:0] dropc_w = mon_ok_w ? dropc_q[mon_chan] : 4'h0;
  wire max_hit_w = over_w && (maxc_w >= atr_pkg::CONSEC - 4'h1);
  wire drop_hit_w = drop_w && (dropc_w >= atr_pkg::CONSEC - 4'h1);
  wire en_w = mon_lp_w ? lowpower_retune_enable : retune_enable;
  // a fault holdoff blocks only the automatic path, never the host bit
  wire trig_w = mon_ok_w && en_w && (hold_q == 8'h00) && (state_q == atr_pkg::S_IDLE)
              && (drift_w || max_hit_w || drop_hit_w);

  // search start: held off while the host still owns the bus
  wire start_w = (state_q == atr_pkg::S_IDLE) && (run_q || pend_q)
               && !comm_window_open;
  wire last_w = mode_q ? (ch_q == atr_pkg::LP_LAST) : (ch_q == atr_pkg::TP_LAST);
  wire fin_ch_w = (state_q == atr_pkg::S_FINAL) && meas_done;
  wire fin_w = fin_ch_w && last_w;
  wire ch_err_w = (comp_q <= comp_low_limit) || (comp_q >= comp_high_limit)
                || atr_pkg::out_rng(meas_count, srch_tgt_w, srch_lim_w);
  wire err_any_w = err_q || ch_err_w;
  wire ms_tick_w = tick_cnt_q == 18'(RETRY_UNIT_CYC - 1);

  // charge transfer frequency from hardware settings
  wire [6:0] phase_w = atr_pkg::PHASE_BASE + {1'b0, atr_pkg::len_term(charge_up_length)}
                     + {1'b0, atr_pkg::len_term(charge_pass_length)}
                     + {5'h00, extra_phase};
  wire [13:0] fcc_div_w = {7'h00, phase_w} << (atr_pkg::CK_TOP - charge_clock_divider_sel);
  wire [31:0] fcc_w = 32'(atr_pkg::FCC_REF_HZ) / {18'h0, fcc_div_w};

  // outputs
  assign meas_req = (state_q == atr_pkg::S_MEAS) || (state_q == atr_pkg::S_FINAL);
  assign meas_chan = ch_q;
  assign meas_comp = comp_q;
  assign meas_gain = gain_q;
  assign run_autotune_bit = run_q;
  assign comm_hold = state_q != atr_pkg::S_IDLE;
  assign retune_happened = tp_rt_q;
  assign lowpower_retune_happened = lp_rt_q;
  assign tune_fault = tp_fault_q;
  assign lowpower_tune_fault = lp_fault_q;
  assign retry_holdoff = hold_q != 8'h00;
  assign charge_freq_hz = freq_q;

  // compensation results, one entry per channel and low-power rx
  atr_comp_mem u_mem (
    .clock(clock),
    .we(fin_ch_w),
    .waddr(ch_q),
    .wdata(comp_q),
    .raddr(comp_rd_addr),
    .rdata(comp_rd_data)
  );

  // search sequencer: binary search per channel, then a checking sample
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= atr_pkg::S_IDLE;
      ch_q <= atr_pkg::TP_FIRST;
      comp_q <= atr_pkg::COMP_RST;
      bit_q <= atr_pkg::SAR_TOP;
      mode_q <= 1'b0;
      retune_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      case (state_q)
        atr_pkg::S_IDLE: begin
          if (start_w) begin
            mode_q <= lowpower_mode;
            ch_q <= lowpower_mode ? atr_pkg::LP_FIRST : atr_pkg::TP_FIRST;
            retune_q <= pend_q;
            err_q <= 1'b0;
            comp_q <= atr_pkg::COMP_RST;
            bit_q <= atr_pkg::SAR_TOP;
            state_q <= atr_pkg::S_TRY;
          end
        end
        atr_pkg::S_TRY: begin
          comp_q <= comp_q | bit_q;
          state_q <= atr_pkg::S_MEAS;
        end
        atr_pkg::S_MEAS: begin
          if (meas_done) begin
            // too much compensation pulls the count under target
            if (meas_count < srch_tgt_w) begin
              comp_q <= comp_q & ~bit_q;
            end
            bit_q <= bit_q >> 1;
            state_q <= (bit_q == 8'h01) ? atr_pkg::S_FINAL : atr_pkg::S_TRY;
          end
        end
        atr_pkg::S_FINAL: begin
          if (meas_done) begin
            err_q <= err_any_w;
            if (last_w) begin
              state_q <= atr_pkg::S_IDLE;
            end else begin
              ch_q <= ch_q + 5'h01;
              comp_q <= atr_pkg::COMP_RST;
              bit_q <= atr_pkg::SAR_TOP;
              state_q <= atr_pkg::S_TRY;
            end
          end
        end
        default: state_q <= atr_pkg::S_IDLE;
      endcase
    end
  end

  // gain registered one cycle ahead of each measurement
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_q <= 8'h00;
    end else begin
      gain_q <= gain_w;
    end
  end

  // host run bit and retune request; a new set beats the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      run_q <= run_autotune_set || (run_q && !fin_w);
      pend_q <= trig_w || (pend_q && !start_w);
    end
  end

  // fault flags move only at the end of a search of their own mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tp_fault_q <= 1'b0;
      lp_fault_q <= 1'b0;
      tp_rt_q <= 1'b0;
      lp_rt_q <= 1'b0;
    end else begin
      if (fin_w && !mode_q) begin
        tp_fault_q <= err_any_w;
      end
      if (fin_w && mode_q) begin
        lp_fault_q <= err_any_w;
      end
      tp_rt_q <= fin_w && retune_q && !mode_q;
      lp_rt_q <= fin_w && retune_q && mode_q;
    end
  end

  // retry holdoff in millisecond steps from a free divider
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 18'h00000;
      hold_q <= 8'h00;
    end else begin
      tick_cnt_q <= ms_tick_w ? 18'h00000 : tick_cnt_q + 18'h00001;
      if (fin_w && err_any_w) begin
        hold_q <= retry_time;
      end else if (ms_tick_w && (hold_q != 8'h00)) begin
        hold_q <= hold_q - 8'h01;
      end
    end
  end

  // consecutive-sample counters per channel, cleared by any sample that misses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < atr_pkg::NCH; i++) begin
        maxc_q[i] <= 4'h0;
        dropc_q[i] <= 4'h0;
      end
    end else if (mon_ok_w) begin
      maxc_q[mon_chan] <= !over_w ? 4'h0 : (maxc_w == atr_pkg::CONSEC)
                        ? maxc_w : maxc_w + 4'h1;
      dropc_q[mon_chan] <= !drop_w ? 4'h0 : (dropc_w == atr_pkg::CONSEC)
                         ? dropc_w : dropc_w + 4'h1;
    end
  end

  // frequency result registered to keep the divider off the output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freq_q <= 23'h000000;
    end else begin
      freq_q <= fcc_w[22:0];
    end
  end

  // checks
  property p_run_clear;
    @(posedge clock) disable iff (rst) fin_w && !run_autotune_set |=> !run_autotune_bit;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run bit not cleared");

  property p_no_start_open;
    @(posedge clock) disable iff (rst)
      $rose(comm_hold) |-> !$past(comm_window_open);
  endproperty
  a_no_start_open: assert property (p_no_start_open) else $error("search in window");

  property p_rt_pulse;
    @(posedge clock) disable iff (rst)
      retune_happened |-> $past(fin_w) ##1 !retune_happened;
  endproperty
  a_rt_pulse: assert property (p_rt_pulse) else $error("retune pulse wrong");

  property p_fault_hold;
    @(posedge clock) disable iff (rst)
      $changed(tune_fault) || $changed(lowpower_tune_fault) |-> $past(fin_w);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault moved");

  property p_tp_gain;
    @(posedge clock) disable iff (rst)
      !ch_lp_w && channel_gain_adjust == 8'h00 |-> gain_w == global_gain_multiplier;
  endproperty
  a_tp_gain: assert property (p_tp_gain) else $error("trackpad gain wrong");

  property p_lp_gain;
    @(posedge clock) disable iff (rst)
      meas_req && meas_chan >= atr_pkg::LP_FIRST |-> meas_gain == lowpower_gain_multiplier;
  endproperty
  a_lp_gain: assert property (p_lp_gain) else $error("low-power gain wrong");

  property p_mode_chan;
    @(posedge clock) disable iff (rst) comm_hold && mode_q |-> meas_chan >= atr_pkg::LP_FIRST;
  endproperty
  a_mode_chan: assert property (p_mode_chan) else $error("wrong mode channel");

  property p_snap_skip;
    @(posedge clock) disable iff (rst) mon_valid && mon_snap |-> !drop_hit_w;
  endproperty
  a_snap_skip: assert property (p_snap_skip) else $error("snap drop trigger");

  property p_max_reset;
    @(posedge clock) disable iff (rst)
      mon_ok_w && !over_w |=> maxc_q[$past(mon_chan)] == 4'h0;
  endproperty
  a_max_reset: assert property (p_max_reset) else $error("counter not reset");

  property p_holdoff;
    @(posedge clock) disable iff (rst) retry_holdoff && !pend_q |=> !pend_q;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("retune during holdoff");

  property p_err_low;
    @(posedge clock) disable iff (rst) fin_w && comp_q <= comp_low_limit && !mode_q
      |=> tune_fault;
  endproperty
  a_err_low: assert property (p_err_low) else $error("fault not flagged");

  property p_fcc_dflt;
    @(posedge clock) disable iff (rst)
      charge_clock_divider_sel == 3'h7 && charge_up_length == 3'h4
      && charge_pass_length == 3'h3 && extra_phase == 2'h0 |=> charge_freq_hz == 23'h1B2071;
  endproperty
  a_fcc_dflt: assert property (p_fcc_dflt) else $error("charge freq wrong");

  c_search: cover property (@(posedge clock) disable iff (rst) fin_w && !mode_q);
  c_lp_retune: cover property (@(posedge clock) disable iff (rst) lowpower_retune_happened);
  c_fault: cover property (@(posedge clock) disable iff (rst) $rose(tune_fault));
endmodule : atr_tune_ctrl

// >>> tb/atr_sense_model.sv
// sensing front end: answers each measurement with a count that falls as compensation rises
module atr_sense_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic meas_req,
  input wire logic [7:0] meas_comp,
  input wire logic slow,
  output logic meas_done,
  output logic [15:0] meas_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // answer promptly or four cycles late; count is garbage outside the answer cycle
  initial begin
    meas_done = 1'b0;
    meas_count = 16'hA5A5;
    forever begin
      @(posedge clock);
      #1;
      if (meas_req === 1'b1 && rst === 1'b0) begin
        if (slow) repeat (4) @(posedge clock);
        if (slow) #1;
        meas_done = 1'b1;
        meas_count = 16'h2000 - {3'h0, meas_comp, 5'h00};
        @(posedge clock);
        #1;
        meas_done = 1'b0;
        meas_count = ~meas_count;
      end
    end
  end
endmodule : atr_sense_model

// >>> tb/auto_tune_retune_control_test.sv
module auto_tune_retune_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst, run_autotune_set, lowpower_mode, comm_window_open, retune_enable, slow;
  logic lowpower_retune_enable, mon_valid, mon_snap;
  logic [7:0] global_gain_multiplier, lowpower_gain_multiplier, channel_gain_adjust;
  logic [7:0] comp_low_limit, comp_high_limit, retry_time, tp_cnt, lp_cnt;
  logic [15:0] tp_target, lp_target, tp_drift_limit, lp_drift_limit, max_count_limit;
  logic [15:0] min_count_drop, mon_count, mon_ref;
  logic [4:0] mon_chan, comp_rd_addr;
  logic [2:0] charge_clock_divider_sel, charge_up_length, charge_pass_length;
  logic [1:0] extra_phase;
  logic [10:0] cfg;
  wire logic run_autotune_bit, comm_hold, meas_req, meas_done, retune_happened, tune_fault;
  wire logic lowpower_retune_happened, lowpower_tune_fault, retry_holdoff;
  wire logic [4:0] meas_chan;
  wire logic [7:0] meas_comp, meas_gain, comp_rd_data;
  wire logic [15:0] meas_count;
  wire logic [22:0] charge_freq_hz;
  logic [2:0] kq[$];
  logic [22:0] vq[$];
  integer seed, n_errors, n_compared, cyc, i;

  atr_tune_ctrl #(.RETRY_UNIT_CYC(20)) u_atr_tune_ctrl (.clock, .rst, .global_gain_multiplier,
    .lowpower_gain_multiplier, .channel_gain_adjust, .run_autotune_set, .run_autotune_bit,
    .lowpower_mode, .comm_window_open, .comm_hold, .tp_target, .lp_target, .tp_drift_limit,
    .lp_drift_limit, .max_count_limit, .min_count_drop, .comp_low_limit, .comp_high_limit,
    .retry_time, .retune_enable, .lowpower_retune_enable, .mon_valid, .mon_chan, .mon_count,
    .mon_ref, .mon_snap, .meas_req, .meas_chan, .meas_comp, .meas_gain, .meas_done, .meas_count,
    .retune_happened, .lowpower_retune_happened, .tune_fault, .lowpower_tune_fault,
    .retry_holdoff, .comp_rd_addr, .comp_rd_data, .charge_clock_divider_sel, .charge_up_length,
    .charge_pass_length, .extra_phase, .charge_freq_hz);
  atr_sense_model u_atr_sense_model (.clock, .rst, .meas_req, .meas_comp, .slow, .meas_done,
    .meas_count);

  // per-channel adjust table, signed, looked up from the channel under measurement
  assign channel_gain_adjust = (meas_chan < 5'h10) ? ({3'h0, meas_chan} * 8'h05 - 8'h28) : 8'h00;

  always #2.5 clock = ~clock;

  function automatic int lt(input logic [2:0] l);
    return (l > 3'h4) ? (1 << (l - 2)) : int'(l);
  endfunction : lt

  function automatic logic [22:0] fexp(input logic [10:0] s);
    return 23'(16000000 / ((2 + lt(s[7:5]) + lt(s[4:2]) + s[1:0]) << (7 - s[10:8])));
  endfunction : fexp

  // compensation the search must land on, given the front end's count curve
  function automatic logic [7:0] sar(input logic [15:0] t);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
      if (16'h2000 - {3'h0, c | (8'h01 << b), 5'h00} >= t) c = c | (8'h01 << b);
    return c;
  endfunction : sar

  function automatic logic [7:0] gexp(input logic [4:0] c);
    int s;
    s = int'(global_gain_multiplier) + int'($signed(channel_gain_adjust));
    if (c > 5'h0F) return lowpower_gain_multiplier;
    return (s > 255) ? 8'hFF : (s < 0) ? 8'h00 : 8'(s);
  endfunction : gexp

  function automatic logic [22:0] obs(input logic [2:0] k);
    case (k)
      3'h0: return charge_freq_hz;
      3'h1: return {22'h0, run_autotune_bit};
      3'h2: return {22'h0, tune_fault};
      3'h3: return {22'h0, lowpower_tune_fault};
      3'h4: return {15'h0, comp_rd_data};
      3'h5: return {22'h0, comm_hold};
      3'h6: return {22'h0, retry_holdoff};
      default: return {7'h0, lp_cnt, tp_cnt};
    endcase
  endfunction : obs

  task chk(input logic [22:0] seen, input logic [22:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task note(input logic [2:0] k, input logic [22:0] v);
    kq.push_back(k);
    vq.push_back(v);
  endtask : note

  task tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : tick

  task run_set;
    run_autotune_set = 1'b1;
    tick(1);
    run_autotune_set = 1'b0;
  endtask : run_set

  task mon(input logic [4:0] ch, input logic [15:0] c, input logic [15:0] rv, input logic sn,
           input int n);
    repeat (n) begin
      {mon_valid, mon_chan, mon_count, mon_ref, mon_snap} = {1'b1, ch, c, rv, sn};
      tick(1);
    end
    mon_valid = 1'b0;
    mon_count = 16'($random(seed));
    // let an edge pass so a following call never drives the strobe twice in one step
    tick(1);
  endtask : mon

  // wait for a search to start (or not), then for it to finish
  task search(input logic exp);
    i = 0;
    while (i < 40 && comm_hold !== 1'b1) begin
      tick(1);
      i++;
    end
    note(3'h5, {22'h0, exp});
    i = 0;
    while (comm_hold === 1'b1 && i < 8000) begin
      tick(1);
      i++;
    end
    if (i == 8000) n_errors++;
    tick(2);
  endtask : search

  // checker side: takes every pending note, oldest first, once outputs have settled
  always @(negedge clock) while (kq.size() > 0) chk(obs(kq.pop_front()), vq.pop_front());

  // every answered measurement must carry the right gain and a channel of the current mode
  always @(negedge clock) begin
    if (meas_req === 1'b1 && meas_done === 1'b1) begin
      chk(meas_gain, gexp(meas_chan));
      chk(lowpower_mode ? meas_chan > 5'h0F && meas_chan < 5'h14 : meas_chan < 5'h10, 1);
    end
  end

  // count retune pulses and cut a hung run short
  always @(posedge clock) begin
    tp_cnt <= tp_cnt + 8'(retune_happened === 1'b1);
    lp_cnt <= lp_cnt + 8'(lowpower_retune_happened === 1'b1);
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    {clock, rst, run_autotune_set, lowpower_mode, comm_window_open, slow} = 6'h12;
    {retune_enable, lowpower_retune_enable, mon_valid, mon_snap, tp_cnt, lp_cnt} = 20'h0;
    // read address parked out of range so the unreset store reads back as zero
    {seed, n_errors, n_compared, cyc, mon_chan, comp_rd_addr} = {32'hE041B406, 96'h0, 5'h00, 5'h1F};
    {global_gain_multiplier, lowpower_gain_multiplier, comp_low_limit} = 24'hF0550A;
    {comp_high_limit, retry_time, mon_count, mon_ref} = 48'hF0020000_0000;
    {tp_target, lp_target, tp_drift_limit, lp_drift_limit} = 64'h1234_0FE0_0100_0080;
    {max_count_limit, min_count_drop} = 32'h3000_0040;
    {charge_clock_divider_sel, charge_up_length, charge_pass_length, extra_phase} = 11'h78C;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    for (i = 1; i < 8; i++) note(3'(i), 23'h0);
    tick(1);
    $display("test reset done");
    for (int j = 0; j < 14; j++) begin
      cfg = (j == 0) ? 11'h78C : 11'($random(seed));
      {charge_clock_divider_sel, charge_up_length, charge_pass_length, extra_phase} = cfg;
      tick(1);
      note(3'h0, fexp(cfg));
    end
    $display("test frequency done");
    run_set();
    tick(20);
    note(3'h5, 23'h0);
    note(3'h1, 23'h1);
    comm_window_open = 1'b0;
    search(1'b1);
    note(3'h1, 23'h0);
    note(3'h2, 23'h0);
    for (int j = 0; j < 16; j++) begin
      comp_rd_addr = 5'(j);
      tick(1);
      note(3'h4, {15'h0, sar(tp_target)});
    end
    $display("test host search done");
    comp_high_limit = 8'h60;
    run_set();
    search(1'b1);
    note(3'h2, 23'h1);
    note(3'h6, 23'h1);
    comp_high_limit = 8'hF0;
    // lower limit equal to the settled compensation must fault as well
    comp_low_limit = sar(tp_target);
    run_set();
    search(1'b1);
    note(3'h2, 23'h1);
    comp_low_limit = 8'h0A;
    retune_enable = 1'b1;
    mon(5'h02, tp_target, 16'h1400, 1'b0, 1);
    search(1'b0);
    note(3'h2, 23'h1);
    i = 0;
    while (retry_holdoff === 1'b1 && i < 300) begin
      tick(1);
      i++;
    end
    note(3'h6, 23'h0);
    mon(5'h02, tp_target, 16'h1400, 1'b0, 1);
    search(1'b1);
    note(3'h2, 23'h0);
    note(3'h7, 23'h1);
    $display("test fault holdoff done");
    mon(5'h03, 16'h3001 + (16'($random(seed)) & 16'h000F), tp_target, 1'b0, 14);
    mon(5'h03, tp_target, tp_target, 1'b0, 1);
    mon(5'h03, 16'h3001 + (16'($random(seed)) & 16'h000F), tp_target, 1'b0, 14);
    search(1'b0);
    mon(5'h03, 16'h3001, tp_target, 1'b0, 1);
    search(1'b1);
    mon(5'h04, 16'h11F3 - (16'($random(seed)) & 16'h000F), tp_target, 1'b1, 15);
    search(1'b0);
    mon(5'h04, 16'h11F3 - (16'($random(seed)) & 16'h000F), tp_target, 1'b0, 15);
    search(1'b1);
    note(3'h7, 23'h3);
    $display("test count triggers done");
    mon(5'h05, tp_target, 16'h1334, 1'b0, 1);
    mon(5'h05, tp_target, 16'h1134, 1'b0, 1);
    search(1'b0);
    mon(5'h05, tp_target, 16'h1133, 1'b0, 1);
    search(1'b1);
    note(3'h7, 23'h4);
    $display("test drift done");
    {lowpower_mode, lowpower_retune_enable, retune_enable, slow} = 4'hD;
    mon(5'h11, lp_target, 16'h0F5F, 1'b0, 1);
    search(1'b1);
    note(3'h7, 23'h104);
    note(3'h3, 23'h0);
    for (int j = 16; j < 20; j++) begin
      comp_rd_addr = 5'(j);
      tick(1);
      note(3'h4, {15'h0, sar(lp_target)});
    end
    tick(2);
    $display("test low-power done");
    wrap_up();
  end
endmodule : auto_tune_retune_control_test
